/* design/modem_gate.sv */
// modem-control outputs and transmit/receive gating for one serial port
`timescale 1ns/100ps
`include "modem_gate_consts.svh"
module modem_gate #(
  parameter int WIDTH = `DATA_WIDTH_DEF,
  parameter int DEPTH = `FIFO_DEPTH_DEF
) (
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  // configuration levels
  input  wire logic                     full_duplex,
  input  wire logic                     term_ready,
  input  wire logic                     sec_rts_req,
  input  wire logic                     auto_rate,
  input  wire logic [31:0]              cfg_baud,
  input  wire logic [WIDTH-1:0]         line_turnaround_char,
  input  wire logic                     proto_rts_on,
  input  wire logic                     proto_rts_off,
  // transmit stream from controller
  input  wire logic [WIDTH-1:0]         tx_data,
  input  wire logic                     tx_valid,
  output logic                          tx_ready,
  // stream to the serializer
  output logic [WIDTH-1:0]              ser_data,
  output logic                          ser_valid,
  input  wire logic                     ser_ready,
  input  wire logic                     ser_busy,
  input  wire logic                     ser_line,
  // receive stream
  input  wire logic [WIDTH-1:0]         rx_in_data,
  input  wire logic                     rx_in_valid,
  output logic [WIDTH-1:0]              rx_data,
  output logic                          rx_valid,
  output logic                          rx_dropped,
  // modem pins
  output logic                          txd,
  output logic                          rts,
  output logic                          dtr,
  output logic                          rate_sel,
  output logic                          sec_rts,
  input  wire logic                     cts,
  input  wire logic                     dsr,
  input  wire logic                     dcd,
  input  wire logic                     dcd_connected,
  input  wire logic                     ring,
  input  wire logic                     sec_dcd,
  // status
  output logic                          ring_seen,
  output logic                          carrier_on,
  output logic [31:0]                   eff_baud
);
  import modem_gate_pkg::*;

  if (WIDTH < 1 || DEPTH < 2) begin : g_bad_params
    $error("modem_gate: bad parameters");
  end

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [4:0][1:0] sync;
    rts_state_e      rts_st;
    logic            txd;
    logic            dtr;
    logic            rate_sel;
    logic            sec_rts;
    logic            ring_seen;
    logic [WIDTH-1:0] rx_data;
    logic            rx_valid;
    logic            rx_dropped;
    logic [31:0]     eff_baud;
  } gate_s;

  gate_s st;
  gate_s next_st;

  // synchroniser taps: second stage only
  logic s_cts;
  logic s_dsr;
  logic s_dcd;
  logic s_ring;
  logic s_sdcd;
  logic [4:0] raw_in;
  logic dcd_eff;

  // an unconnected carrier line counts as carrier present
  assign dcd_eff = dcd || !dcd_connected;
  assign raw_in  = {sec_dcd, ring, dcd_eff, dsr, cts};
  assign s_cts   = st.sync[0][1];
  assign s_dsr   = st.sync[1][1];
  assign s_dcd   = st.sync[2][1];
  assign s_ring  = st.sync[3][1];
  assign s_sdcd  = st.sync[4][1];

  //////////////////////////////////////////////////////////////////////////////
  logic [WIDTH-1:0] f_data;
  logic             f_valid;
  logic             f_ready;
  logic             tx_allow;
  logic             rts_on;

  word_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) tx_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .flush     (1'b0)
  );

  assign rts_on   = full_duplex || (st.rts_st != rts_idle);
  // starting a word needs cts and dsr; fifo stalls meanwhile
  assign tx_allow = s_cts && s_dsr && rts_on;
  assign ser_valid = f_valid && tx_allow;
  assign ser_data  = f_data;
  assign f_ready   = ser_ready && tx_allow;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    for (int i = 0; i < 5; i++) begin
      next_st.sync[i] = {st.sync[i][0], raw_in[i]};
    end
    // idle line held at mark unless serializer busy and dsr present
    next_st.txd = (ser_busy && s_dsr) ? ser_line : `MARK_LEVEL;
    next_st.dtr = term_ready;
    next_st.sec_rts = sec_rts_req;
    next_st.ring_seen = s_ring;
    // half duplex keying from turnaround character and protocol
    unique case (st.rts_st)
      rts_idle: begin
        if (proto_rts_on) next_st.rts_st = rts_keyed;
      end
      rts_keyed: begin
        if (proto_rts_off) next_st.rts_st = rts_idle;
        else if (f_valid && f_ready && f_data == line_turnaround_char) begin
          next_st.rts_st = rts_drain;
        end
      end
      rts_drain: begin
        // drop rts only after the turnaround char has left the line
        if (!ser_busy && !f_valid) next_st.rts_st = rts_idle;
      end
    endcase
    if (auto_rate) begin
      next_st.eff_baud = s_sdcd ? `AUTO_HIGH_BAUD : `AUTO_LOW_BAUD;
    end else begin
      next_st.eff_baud = cfg_baud;
    end
    next_st.rate_sel = (next_st.eff_baud >= `RATE_SEL_MIN_BAUD);
    next_st.rx_valid   = 1'b0;
    next_st.rx_dropped = 1'b0;
    if (rx_in_valid) begin
      if (s_dcd && s_dsr) begin
        next_st.rx_valid = 1'b1;
        next_st.rx_data  = rx_in_data;
      end else begin
        next_st.rx_dropped = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st        <= '0;
      st.txd    <= `MARK_LEVEL;
      st.rts_st <= rts_idle;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign txd        = st.txd;
  assign rts        = rts_on;
  assign dtr        = st.dtr;
  assign rate_sel   = st.rate_sel;
  assign sec_rts    = st.sec_rts;
  assign ring_seen  = st.ring_seen;
  assign carrier_on = s_dcd;
  assign rx_data    = st.rx_data;
  assign rx_valid   = st.rx_valid;
  assign rx_dropped = st.rx_dropped;
  assign eff_baud   = st.eff_baud;
endmodule : modem_gate

/* design/modem_gate_consts.svh */
// constants for the modem-control and line-gating block
// Notes on behaviour
// - idle transmit line sits at mark, logic one.
// - full duplex keeps request-to-send asserted continuously.
// - half duplex keys request-to-send from turnaround characters and protocol.
// - no transmission starts while clear-to-send is off.
// - data-set-ready off blocks both transmit and receive.
// - data-terminal-ready asserted when ready to connect, timing by software.
// - ring input from modem is made observable to decide originate or answer.
// - received data is discarded while carrier-detect is off.
// - floating carrier-detect reads as asserted.
// - rate-select asserted at 1200 baud or above, else deasserted.
// - secondary request-to-send driven under the selected protocol.
// - optional automatic rate following of secondary carrier-detect.
`ifndef MODEM_GATE_CONSTS_SVH
`define MODEM_GATE_CONSTS_SVH
`define RATE_SEL_MIN_BAUD   32'd1200
`define AUTO_HIGH_BAUD      32'd1200
`define AUTO_LOW_BAUD       32'd300
`define MARK_LEVEL          1'b1
`define FIFO_DEPTH_DEF      4
`define DATA_WIDTH_DEF      8
`endif

/* design/modem_gate_pkg.sv */
// types for the modem-control and line-gating block
package modem_gate_pkg;
  typedef enum logic [1:0] {
    rts_idle,
    rts_keyed,
    rts_drain
  } rts_state_e;
endpackage : modem_gate_pkg

/* design/word_fifo.sv */
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  input  wire logic             flush
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // a single entry would leave the pointers with nothing to wrap
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_params
    $error("word_fifo: bad parameters");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 cnt;
  } fifo_s;

  fifo_s st;
  fifo_s next_st;
  logic  push;
  logic  pop;

  assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data  = st.mem[st.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + AW'(1);
    end
    if (pop) begin
      next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + AW'(1);
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      next_st.rd  = '0;
      next_st.wr  = '0;
      next_st.cnt = '0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : word_fifo

/* test/modem_gate_asserts.sv */
// port checker for modem_gate
`timescale 1ns/100ps
`include "modem_gate_consts.svh"
module modem_gate_asserts (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        full_duplex,
  input wire logic        rts,
  input wire logic        ser_busy,
  input wire logic        txd,
  input wire logic        dsr,
  input wire logic        cts,
  input wire logic        ser_valid,
  input wire logic        auto_rate,
  input wire logic [31:0] cfg_baud,
  input wire logic        rate_sel,
  input wire logic        sec_dcd,
  input wire logic [31:0] eff_baud,
  input wire logic        dcd,
  input wire logic        dcd_connected,
  input wire logic        rx_in_valid,
  input wire logic        rx_dropped,
  input wire logic        ring,
  input wire logic        ring_seen
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_rts_full_duplex: assert property (full_duplex |-> rts) else $error("rts off");
  a_idle_mark: assert property (!ser_busy ##1 1 |-> txd) else $error("txd not mark");
  a_dsr_gate: assert property (!dsr [*3] |-> !ser_valid) else $error("sent, dsr off");
  a_cts_gate: assert property (!cts [*3] |-> !ser_valid) else $error("sent, cts off");
  a_rate_sel_level:
    assert property ((!auto_rate && $stable(cfg_baud)) [*4] |-> rate_sel ==
      (cfg_baud >= `RATE_SEL_MIN_BAUD)) else $error("rate select wrong");
  a_auto_rate_follow:
    assert property ((auto_rate && $stable(sec_dcd)) [*5] |-> eff_baud ==
      (sec_dcd ? `AUTO_HIGH_BAUD : `AUTO_LOW_BAUD)) else $error("auto rate wrong");
  a_carrier_drop:
    assert property ((dcd_connected && !dcd) [*3] ##0 rx_in_valid |=> rx_dropped)
      else $error("rx kept without carrier");
  a_ring_seen: assert property (ring [*4] |-> ring_seen) else $error("ring unseen");
  cover property (ser_valid && !full_duplex);
  cover property (rx_in_valid && !dcd);
  cover property (auto_rate && sec_dcd);
endmodule : modem_gate_asserts
bind modem_gate modem_gate_asserts u_chk (.*);

/* test/modem_model.sv */
// behavioural modem at the far end of the port
`timescale 1ns/100ps
module modem_model (
  input wire logic       mclk,
  input wire logic       rts,
  input wire logic       online,
  input wire logic       carrier,
  input wire logic       fast,
  input wire logic       ringing,
  input wire logic [2:0] lag,
  output logic           cts,
  output logic           dsr,
  output logic           dcd,
  output logic           ring,
  output logic           sec_dcd
);
  logic [2:0] cnt = 3'h0;
  // cts takes lag cycles to come up after rts
  always @(posedge mclk) begin
    cnt <= !rts ? 3'h0 : (cnt == 3'h7 ? cnt : cnt + 3'h1);
  end
  assign cts = rts && cnt >= lag;
  assign dsr = online;
  assign dcd = carrier;
  assign ring = ringing;
  assign sec_dcd = fast;
endmodule : modem_model

/* test/tb_serial_modem_control_gating.sv */
// bench for modem_gate with a modem model
`timescale 1ns/100ps
`include "modem_gate_consts.svh"
module tb_serial_modem_control_gating;
  logic mclk, resetn, full_duplex, term_ready, sec_rts_req, auto_rate, proto_rts_on;
  logic proto_rts_off, tx_valid, tx_ready, ser_valid, ser_ready, ser_busy, ser_line, txd, rts;
  logic rx_in_valid, rx_valid, rx_dropped, dtr, rate_sel, sec_rts, cts, dsr, dcd, ring, sec_dcd;
  logic dcd_connected, ring_seen, carrier_on, online, carrier, fast, ringing, stall, go, tr_d, sr_d;
  logic [31:0] cfg_baud, eff_baud, lfsr = 32'h0000_bb56;
  logic [7:0]  line_turnaround_char, tx_data, ser_data, rx_in_data, rx_data, txq[$], rxq[$];
  logic [2:0]  lag;
  logic [31:0] bauds[4] = '{32'h0000_012c, 32'h0000_04af, 32'h0000_04b0, 32'h0000_2580};
  int          num_errors = 0;
  int          comparisons = 0;
  int          drops = 0;
  logic        bz_d;
  modem_gate u_dut (.*);
  modem_model u_modem (.*);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic send(input logic [7:0] w);
    tx_data <= w;
    tx_valid <= 1'b1;
    do @(posedge mclk); while (tx_ready !== 1'b1);
    txq.push_back(w);
  endtask : send
  task automatic drain;
    tx_valid <= 1'b0;
    for (int i = 0; i < 300 && txq.size() > 0; i++) @(posedge mclk);
    check(txq.size(), 0, "tx drained");
  endtask : drain
  task automatic rxb(input int n, input bit keep);
    for (int i = 0; i < n; i++) begin
      rx_in_data <= lfsr[15:8];
      rx_in_valid <= 1'b1;
      if (keep) rxq.push_back(lfsr[15:8]);
      @(posedge mclk);
    end
    rx_in_valid <= 1'b0;
  endtask : rxb
  // random serializer handshake and config levels
  always @(posedge mclk) begin
    lfsr <= lfsr_next(lfsr);
    bz_d <= ser_busy;
    if (go && !bz_d) check(txd, `MARK_LEVEL, "txd idle");
    if (rx_dropped) drops++;
    ser_ready <= !stall && lfsr[3];
    ser_busy <= lfsr[5];
    ser_line <= lfsr[7];
    term_ready <= lfsr[9];
    sec_rts_req <= lfsr[11];
    tr_d <= term_ready;
    sr_d <= sec_rts_req;
    if (go) check(dtr, tr_d, "dtr");
    if (go) check(sec_rts, sr_d, "sec_rts");
    if (ser_valid && ser_ready) check(ser_data, txq.size() ? txq.pop_front() : 8'hxx, "ser");
    if (rx_valid) check(rx_data, rxq.size() ? rxq.pop_front() : 8'hxx, "rx_data");
  end
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    print_verdict();
  end
  initial begin
    {resetn, auto_rate, proto_rts_on, proto_rts_off, tx_valid, rx_in_valid, fast, ringing} = 0;
    {full_duplex, stall, online, carrier, dcd_connected, ser_line} = 6'h3f;
    {go, term_ready, sec_rts_req, ser_ready, ser_busy, tr_d, sr_d, bz_d} = 0;
    {tx_data, rx_in_data, line_turnaround_char, lag, cfg_baud} = {16'h0000, 8'h0d, 3'h1, bauds[3]};
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    go <= 1'b1;
    // far side stalled: fill until refused, then drain
    for (int i = 0; i < 4; i++) send(lfsr[7:0]);
    tx_valid <= 1'b0;
    @(posedge mclk);
    check(tx_ready, 1'b0, "tx_ready full");
    stall <= 1'b0;
    drain();
    rxb(5, 1);
    online <= 1'b0;
    // let the synchroniser see dsr low before the word arrives
    repeat (2) @(posedge mclk);
    send(8'ha5);
    tx_valid <= 1'b0;
    rxb(2, 0);
    repeat (20) @(posedge mclk);
    check(txq.size(), 1, "held, dsr off");
    check(txd, `MARK_LEVEL, "txd, dsr off");
    online <= 1'b1;
    drain();
    carrier <= 1'b0;
    repeat (3) @(posedge mclk);
    check(carrier_on, 1'b0, "carrier off");
    rxb(3, 0);
    dcd_connected <= 1'b0;
    repeat (3) @(posedge mclk);
    check(carrier_on, 1'b1, "carrier floating");
    rxb(3, 1);
    {carrier, dcd_connected, full_duplex, lag} <= {2'b11, 1'b0, 3'h6};
    send(8'h11);
    tx_valid <= 1'b0;
    repeat (10) @(posedge mclk);
    check(rts, 1'b0, "rts half duplex idle");
    check(txq.size(), 1, "held, rts off");
    proto_rts_on <= 1'b1;
    @(posedge mclk);
    proto_rts_on <= 1'b0;
    send(line_turnaround_char);
    drain();
    for (int i = 0; i < 50 && rts; i++) @(posedge mclk);
    check(rts, 1'b0, "rts after turnaround");
    proto_rts_on <= 1'b1;
    @(posedge mclk);
    {proto_rts_on, proto_rts_off} <= 2'b01;
    @(posedge mclk);
    proto_rts_off <= 1'b0;
    @(posedge mclk);
    check(rts, 1'b0, "rts off pulse");
    foreach (bauds[i]) begin
      cfg_baud <= bauds[i];
      repeat (5) @(posedge mclk);
      check(rate_sel, bauds[i] >= `RATE_SEL_MIN_BAUD, "rate_sel");
    end
    auto_rate <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      fast <= f[0];
      repeat (6) @(posedge mclk);
      check(eff_baud, f ? `AUTO_HIGH_BAUD : `AUTO_LOW_BAUD, "eff_baud");
    end
    check(ring_seen, 1'b0, "ring idle");
    ringing <= 1'b1;
    repeat (5) @(posedge mclk);
    check(ring_seen, 1'b1, "ring_seen");
    check(rxq.size(), 0, "rx all seen");
    check(drops, 5, "rx dropped");
    print_verdict();
  end
endmodule : tb_serial_modem_control_gating
